// File: hw/tlcs_top.sv
// limit comparators, status flags and serial register access
//
// Behaviour
// R1: local high limit written at 0Bh/16h, pairs
// R2: local high limit read at 05h/16h, pairs
// R3: local low limit write 0Ch/17h, read 06h/17h
// R4: remote high write 0Dh/13h, read 07h/13h
// R5: remote low write 0Eh/14h, read 08h/14h
// R6: high limits reset to 55h and 00h
// R7: low limits reset to 00h and 00h
// R8: overtemp limits at 20h and 19h, reset 55h
// R9: shared hysteresis at 21h, reset 0Ah
// R10: host rewrites limits after range change
// R11: status at 02h, read only, fixed bit order
// R12: busy shows a conversion in progress
// R13: open flag latched from remote attempts only
// R14: overtemp flags compare with hysteresis
// R15: high flags latch in interrupt mode
// R16: high flags live hysteretic in overtemp mode
// R17: low flags always latch
// R18: latched flags clear on read if cause ended
// R19: live flags ignore status reads
// R20: status read keeps interrupt pin, alert response releases
// R21: rising latched flag pulls interrupt low
// R22: busy follows the first conversion quickly
// R23: mask bit gates the interrupt pin
// R24: mode bit picks interrupt or overtemp2 pin
// R25: compare full twelve-bit limits
`timescale 1ns/1ps
`include "tlcs_defs.svh"
module tlcs_top #(
    parameter logic [6:0] DEV_ADDR = 7'h2A
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic conv_busy,
    input wire logic conv_done_local,
    input wire logic conv_done_remote,
    input wire logic remote_open,
    input wire tlcs_pkg::tlcs_temp_t conv_result,
    output logic interrupt_out_n,
    output logic overtemp2_out_n,
    output logic overtemp_out_n
);
    import tlcs_pkg::*;

    logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
    tlcs_state_t state;
    logic [3:0] cnt;
    logic [7:0] shreg, txreg, ptr, wr_addr, wr_byte, cfg, hyst;
    logic first, is_read, is_ara, host_ack;
    logic wr_stb, status_rd, ara_clr;
    logic busy, flag_open, cond_open, alert;
    logic [4:0] prev_flags;

    // bus edge and condition detect
    wire scl_rise = scl_s2 & ~scl_s3;
    wire scl_fall = ~scl_s2 & scl_s3;
    wire start_c = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
    wire stop_c = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
    wire pfs = cfg[`TLCS_CFG_PFS];
    wire mask = cfg[`TLCS_CFG_MASK];
    wire byte_full = (cnt == `TLCS_BITS_PER_BYTE);
    wire dev_hit = (shreg[7:1] == DEV_ADDR);
    wire ara_hit = (shreg[7:1] == `TLCS_ARA_ADDR) & shreg[0] & alert;

    // write strobes, 0 local, 1 remote
    wire [1:0] wr_hu = {wr_stb & (wr_addr == `TLCS_PTR_RHU_WR),
                        wr_stb & (wr_addr == `TLCS_PTR_LHU_WR)};
    wire [1:0] wr_hl = {wr_stb & (wr_addr == `TLCS_PTR_RHL),
                        wr_stb & (wr_addr == `TLCS_PTR_LHL)};
    wire [1:0] wr_lu = {wr_stb & (wr_addr == `TLCS_PTR_RLU_WR),
                        wr_stb & (wr_addr == `TLCS_PTR_LLU_WR)};
    wire [1:0] wr_ll = {wr_stb & (wr_addr == `TLCS_PTR_RLL),
                        wr_stb & (wr_addr == `TLCS_PTR_LLL)};
    wire [1:0] wr_ot = {wr_stb & (wr_addr == `TLCS_PTR_ROT),
                        wr_stb & (wr_addr == `TLCS_PTR_LOT)};
    wire wr_cfg = wr_stb & (wr_addr == `TLCS_PTR_CFG_WR);
    wire wr_hyst = wr_stb & (wr_addr == `TLCS_PTR_HYST);
    wire [1:0] done_ch = {conv_done_remote & ~remote_open, conv_done_local};
    wire open_seen = conv_done_remote & remote_open;

    wire [7:0] hi_up_w [0:1];
    wire [3:0] hi_lo_w [0:1];
    wire [7:0] lo_up_w [0:1];
    wire [3:0] lo_lo_w [0:1];
    wire [7:0] ot_w [0:1];
    wire [1:0] flag_hi, flag_lo, flag_ot;

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
            logic [7:0] hi_up, lo_up, ot_lim;
            logic [3:0] hi_lo, lo_lo;
            logic cond_hi, cond_lo, f_hi, f_lo, f_ot;
            // twelve-bit limits and release points
            wire [11:0] hi12 = {hi_up, hi_lo}; // R25
            wire [11:0] lo12 = {lo_up, lo_lo}; // R25
            wire [11:0] hyst12 = {hyst, 4'h0};
            wire [11:0] hi_rel = (hi12 > hyst12) ? hi12 - hyst12 : 12'h000;
            wire [7:0] ot_rel = (ot_lim > hyst) ? ot_lim - hyst : 8'h00; // R9
            wire above_hi = conv_result > hi12; // R25
            wire below_lo = conv_result < lo12; // R25
            wire above_hi_rel = conv_result > hi_rel;
            wire above_ot = conv_result[11:4] > ot_lim;
            wire above_ot_rel = conv_result[11:4] > ot_rel;
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    hi_up <= `TLCS_RST_HI_UP; // R6
                    hi_lo <= `TLCS_RST_LOWER; // R6
                    lo_up <= `TLCS_RST_LO_UP; // R7
                    lo_lo <= `TLCS_RST_LOWER; // R7
                    ot_lim <= `TLCS_RST_OT; // R8
                end else begin
                    if (wr_hu[ch]) hi_up <= wr_byte; // R1 R4
                    if (wr_hl[ch]) hi_lo <= wr_byte[7:4]; // R1 R4
                    if (wr_lu[ch]) lo_up <= wr_byte; // R3 R5
                    if (wr_ll[ch]) lo_lo <= wr_byte[7:4]; // R3 R5
                    if (wr_ot[ch]) ot_lim <= wr_byte; // R8
                end
            end
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    cond_hi <= 1'b0;
                    cond_lo <= 1'b0;
                    f_hi <= 1'b0;
                    f_lo <= 1'b0;
                    f_ot <= 1'b0;
                end else begin
                    if (done_ch[ch]) cond_hi <= above_hi;
                    if (done_ch[ch]) cond_lo <= below_lo;
                    if (pfs) begin
                        if (done_ch[ch]) f_hi <= above_hi | (f_hi & above_hi_rel); // R16 R19
                    end else if (done_ch[ch] & above_hi) begin
                        f_hi <= 1'b1; // R15
                    end else if (status_rd & ~cond_hi) begin
                        f_hi <= 1'b0; // R18
                    end
                    if (done_ch[ch] & below_lo) begin
                        f_lo <= 1'b1; // R17
                    end else if (status_rd & ~cond_lo) begin
                        f_lo <= 1'b0; // R18
                    end
                    if (done_ch[ch]) f_ot <= above_ot | (f_ot & above_ot_rel); // R14 R19
                end
            end
            assign hi_up_w[ch] = hi_up;
            assign hi_lo_w[ch] = hi_lo;
            assign lo_up_w[ch] = lo_up;
            assign lo_lo_w[ch] = lo_lo;
            assign ot_w[ch] = ot_lim;
            assign flag_hi[ch] = f_hi;
            assign flag_lo[ch] = f_lo;
            assign flag_ot[ch] = f_ot;
        end
    endgenerate

    // status byte
    wire [7:0] status_byte = {busy, flag_hi[0], flag_lo[0], flag_hi[1],
                              flag_lo[1], flag_open, flag_ot[1],
                              flag_ot[0]}; // R11

    // read decode, unmapped reads zero
    wire [7:0] rd_data =
        (ptr == `TLCS_PTR_STATUS) ? status_byte : // R11
        (ptr == `TLCS_PTR_CFG_RD) ? cfg :
        (ptr == `TLCS_PTR_LHU_RD) ? hi_up_w[0] : // R2
        (ptr == `TLCS_PTR_LHL) ? {hi_lo_w[0], 4'h0} : // R2
        (ptr == `TLCS_PTR_LLU_RD) ? lo_up_w[0] : // R3
        (ptr == `TLCS_PTR_LLL) ? {lo_lo_w[0], 4'h0} : // R3
        (ptr == `TLCS_PTR_RHU_RD) ? hi_up_w[1] : // R4
        (ptr == `TLCS_PTR_RHL) ? {hi_lo_w[1], 4'h0} : // R4
        (ptr == `TLCS_PTR_RLU_RD) ? lo_up_w[1] : // R5
        (ptr == `TLCS_PTR_RLL) ? {lo_lo_w[1], 4'h0} : // R5
        (ptr == `TLCS_PTR_LOT) ? ot_w[0] : // R8
        (ptr == `TLCS_PTR_ROT) ? ot_w[1] : // R8
        (ptr == `TLCS_PTR_HYST) ? hyst : 8'h00; // R9
    wire [7:0] load_byte = is_ara ? {DEV_ADDR, 1'b0} : rd_data;

    // upper byte steps the pointer to its lower byte
    wire [7:0] next_wr_ptr =
        (ptr == `TLCS_PTR_LHU_WR) ? `TLCS_PTR_LHL : // R1
        (ptr == `TLCS_PTR_LLU_WR) ? `TLCS_PTR_LLL : // R3
        (ptr == `TLCS_PTR_RHU_WR) ? `TLCS_PTR_RHL : // R4
        (ptr == `TLCS_PTR_RLU_WR) ? `TLCS_PTR_RLL : ptr; // R5
    wire [7:0] next_rd_ptr =
        (ptr == `TLCS_PTR_LHU_RD) ? `TLCS_PTR_LHL : // R2
        (ptr == `TLCS_PTR_LLU_RD) ? `TLCS_PTR_LLL : // R3
        (ptr == `TLCS_PTR_RHU_RD) ? `TLCS_PTR_RHL : // R4
        (ptr == `TLCS_PTR_RLU_RD) ? `TLCS_PTR_RLL : ptr; // R5
    wire load_status = ~is_ara & (ptr == `TLCS_PTR_STATUS);

    // bus line synchronisers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            {scl_s1, scl_s2, scl_s3} <= 3'h7;
            {sda_s1, sda_s2, sda_s3} <= 3'h7;
        end else begin
            {scl_s1, scl_s2, scl_s3} <= {scl_in, scl_s1, scl_s2};
            {sda_s1, sda_s2, sda_s3} <= {sda_in, sda_s1, sda_s2};
        end
    end

    // serial register slave
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= TLCS_IDLE;
            cnt <= 4'h0;
            shreg <= 8'h00;
            txreg <= 8'h00;
            ptr <= 8'h00;
            wr_addr <= 8'h00;
            wr_byte <= 8'h00;
            first <= 1'b1;
            is_read <= 1'b0;
            is_ara <= 1'b0;
            host_ack <= 1'b0;
            wr_stb <= 1'b0;
            status_rd <= 1'b0;
            ara_clr <= 1'b0;
            sda_oe_n <= 1'b1;
        end else begin
            wr_stb <= 1'b0;
            status_rd <= 1'b0;
            ara_clr <= 1'b0;
            if (start_c) begin
                state <= TLCS_ADDR;
                cnt <= 4'h0;
                first <= 1'b1;
                sda_oe_n <= 1'b1;
            end else if (stop_c) begin
                state <= TLCS_IDLE;
                sda_oe_n <= 1'b1;
            end else if (scl_rise) begin
                if (state == TLCS_ADDR || state == TLCS_WR) begin
                    shreg <= {shreg[6:0], sda_s2};
                    cnt <= cnt + 4'h1;
                end
                if (state == TLCS_RACK) host_ack <= ~sda_s2;
            end else if (scl_fall) begin
                case (state)
                    TLCS_ADDR: begin
                        if (byte_full) begin
                            if ((dev_hit & ~(shreg[0] & first & 1'b0))
                                | ara_hit) begin
                                sda_oe_n <= 1'b0;
                                state <= TLCS_AACK;
                                is_read <= shreg[0];
                                is_ara <= ara_hit;
                            end else begin
                                state <= TLCS_IDLE;
                            end
                        end
                    end
                    TLCS_AACK: begin
                        cnt <= 4'h0;
                        if (is_read) begin
                            txreg <= load_byte;
                            sda_oe_n <= load_byte[7];
                            status_rd <= load_status;
                            ara_clr <= is_ara; // R20
                            if (!is_ara) ptr <= next_rd_ptr;
                            state <= TLCS_RD;
                        end else begin
                            sda_oe_n <= 1'b1;
                            state <= TLCS_WR;
                        end
                    end
                    TLCS_WR: begin
                        if (byte_full) begin
                            sda_oe_n <= 1'b0;
                            state <= TLCS_WACK;
                            if (first) begin
                                ptr <= shreg;
                                first <= 1'b0;
                            end else begin
                                wr_stb <= 1'b1;
                                wr_addr <= ptr;
                                wr_byte <= shreg;
                                ptr <= next_wr_ptr;
                            end
                        end
                    end
                    TLCS_WACK: begin
                        sda_oe_n <= 1'b1;
                        cnt <= 4'h0;
                        state <= TLCS_WR;
                    end
                    TLCS_RD: begin
                        if (cnt == 4'h7) begin
                            sda_oe_n <= 1'b1;
                            state <= TLCS_RACK;
                        end else begin
                            cnt <= cnt + 4'h1;
                            txreg <= {txreg[6:0], 1'b0};
                            sda_oe_n <= txreg[6];
                        end
                    end
                    TLCS_RACK: begin
                        if (host_ack) begin
                            cnt <= 4'h0;
                            txreg <= load_byte;
                            sda_oe_n <= load_byte[7];
                            status_rd <= load_status;
                            if (!is_ara) ptr <= next_rd_ptr; // R2
                            state <= TLCS_RD;
                        end else begin
                            state <= TLCS_IDLE;
                        end
                    end
                    default: state <= TLCS_IDLE;
                endcase
            end
        end
    end

    // config, hysteresis, busy, open flag
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cfg <= `TLCS_RST_CFG;
            hyst <= `TLCS_RST_HYST; // R9
            busy <= 1'b0;
            flag_open <= 1'b0;
            cond_open <= 1'b0;
        end else begin
            if (wr_cfg) begin
                cfg <= {wr_byte[`TLCS_CFG_MASK], wr_byte[`TLCS_CFG_SD],
                        wr_byte[`TLCS_CFG_PFS], 2'b00,
                        wr_byte[`TLCS_CFG_RANGE], 2'b00};
            end
            if (wr_hyst) hyst <= wr_byte; // R9
            busy <= conv_busy; // R12 R22
            if (conv_done_remote) cond_open <= remote_open;
            if (open_seen) begin
                flag_open <= 1'b1; // R13
            end else if (status_rd & ~cond_open) begin
                flag_open <= 1'b0; // R18
            end
        end
    end

    // alert latch and pin drivers
    wire [4:0] alert_flags = {flag_hi[0], flag_lo[0], flag_hi[1],
                              flag_lo[1], flag_open};
    wire alert_rise = ~pfs & (|(alert_flags & ~prev_flags)); // R21
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prev_flags <= 5'h00;
            alert <= 1'b0;
            interrupt_out_n <= 1'b1;
            overtemp2_out_n <= 1'b1;
            overtemp_out_n <= 1'b1;
            sda_out <= 1'b0;
        end else begin
            prev_flags <= alert_flags;
            if (alert_rise) begin
                alert <= 1'b1; // R21
            end else if (ara_clr) begin
                alert <= 1'b0; // R20
            end
            interrupt_out_n <= ~(alert & ~pfs & ~mask); // R23 R24
            overtemp2_out_n <= ~(pfs & (flag_hi[0] | flag_hi[1])); // R24
            overtemp_out_n <= ~(flag_ot[0] | flag_ot[1]); // R14
            sda_out <= 1'b0;
        end
    end
endmodule : tlcs_top

// File: common/tlcs_defs.svh
// offsets, fields, reset values and bus constants
`ifndef TLCS_DEFS_SVH
`define TLCS_DEFS_SVH
`define TLCS_PTR_STATUS 8'h02
`define TLCS_PTR_CFG_RD 8'h03
`define TLCS_PTR_CFG_WR 8'h09
`define TLCS_PTR_LHU_RD 8'h05
`define TLCS_PTR_LLU_RD 8'h06
`define TLCS_PTR_RHU_RD 8'h07
`define TLCS_PTR_RLU_RD 8'h08
`define TLCS_PTR_LHU_WR 8'h0B
`define TLCS_PTR_LLU_WR 8'h0C
`define TLCS_PTR_RHU_WR 8'h0D
`define TLCS_PTR_RLU_WR 8'h0E
`define TLCS_PTR_RHL 8'h13
`define TLCS_PTR_RLL 8'h14
`define TLCS_PTR_LHL 8'h16
`define TLCS_PTR_LLL 8'h17
`define TLCS_PTR_ROT 8'h19
`define TLCS_PTR_LOT 8'h20
`define TLCS_PTR_HYST 8'h21
`define TLCS_RST_HI_UP 8'h55
`define TLCS_RST_LO_UP 8'h00
`define TLCS_RST_LOWER 4'h0
`define TLCS_RST_OT 8'h55
`define TLCS_RST_HYST 8'h0A
`define TLCS_RST_CFG 8'h00
`define TLCS_CFG_MASK 7
`define TLCS_CFG_SD 6
`define TLCS_CFG_PFS 5
`define TLCS_CFG_RANGE 2
`define TLCS_ARA_ADDR 7'h0C
`define TLCS_BITS_PER_BYTE 4'h8
`endif

// File: common/tlcs_pkg.sv
// types of the limit compare and status block
package tlcs_pkg;
    typedef enum logic [6:0] {
        TLCS_IDLE = 7'h01,
        TLCS_ADDR = 7'h02,
        TLCS_AACK = 7'h04,
        TLCS_WR = 7'h08,
        TLCS_WACK = 7'h10,
        TLCS_RD = 7'h20,
        TLCS_RACK = 7'h40
    } tlcs_state_t;
    typedef logic [11:0] tlcs_temp_t;
endpackage : tlcs_pkg

// File: testbench/tlcs_monitor.sv
// pin assertions of the limit compare and status block
`timescale 1ns/1ps
module tlcs_monitor (
    input logic clk,
    input logic nrst,
    input logic scl_in,
    input logic sda_in,
    input logic sda_out,
    input logic sda_oe_n,
    input logic conv_busy,
    input logic conv_done_local,
    input logic conv_done_remote,
    input logic remote_open,
    input tlcs_pkg::tlcs_temp_t conv_result,
    input logic interrupt_out_n,
    input logic overtemp2_out_n,
    input logic overtemp_out_n
);
    import tlcs_pkg::*;
    logic touched;
    logic [3:0] done_age;
    logic [5:0] idle_age;
    wire done = conv_done_local | conv_done_remote;
    wire [3:0] done_inc = done_age + {3'h0, done_age != 4'hF};
    wire [5:0] idle_inc = idle_age + {5'h00, idle_age != 6'h3F};
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            touched <= 1'b0;
            done_age <= 4'hF;
            idle_age <= 6'h3F;
        end else begin
            touched <= touched | ~sda_oe_n;
            done_age <= done ? 4'h0 : done_inc;
            idle_age <= scl_in ? idle_inc : 6'h00;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    sequence s_hot_local;
        !touched && conv_done_local && conv_result[11:4] > 8'h55;
    endsequence
    sequence s_warm_local;
        !touched && conv_done_local && conv_result[11:4] > 8'h4B
            && !overtemp_out_n;
    endsequence
    a_ot_set: assert property (s_hot_local |-> ##[1:4] !overtemp_out_n)
        else $error("overtemp pin did not fall");
    a_ot_hold: assert property (s_warm_local |=> !overtemp_out_n [*3])
        else $error("overtemp released early");
    a_int_set: assert property (!touched && conv_done_local
        && conv_result > 12'h550 |-> ##[1:5] !interrupt_out_n)
        else $error("alert pin did not fall");
    a_ot_on_done: assert property (!$stable(overtemp_out_n)
        |-> done_age < 4'h5)
        else $error("overtemp pin moved without a conversion");
    a_ot2_cause: assert property ($fell(overtemp2_out_n)
        |-> done_age < 4'h5 || idle_age < 6'h20)
        else $error("overtemp2 pin fell without cause");
    a_int_release: assert property ($rose(interrupt_out_n)
        |-> idle_age < 6'h20)
        else $error("alert released off bus");
    a_pin_modes: assert property (interrupt_out_n || overtemp2_out_n)
        else $error("both alert pins low");
    a_sda_scl_low: assert property (!$stable(sda_oe_n) |-> !scl_in)
        else $error("data line moved while clock high");
endmodule : tlcs_monitor

bind tlcs_top tlcs_monitor tlcs_monitor_i (.clk, .nrst, .scl_in, .sda_in,
    .sda_out, .sda_oe_n, .conv_busy, .conv_done_local, .conv_done_remote,
    .remote_open, .conv_result, .interrupt_out_n, .overtemp2_out_n,
    .overtemp_out_n);

// File: testbench/tlcs_host.sv
// two-wire host controller model for the register port
`timescale 1ns/1ps
`include "tlcs_defs.svh"
module tlcs_host #(
    parameter logic [6:0] ADDR = 7'h2A
) (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_o
);
    int nacks = 0;
    initial begin
        scl = 1'b1;
        sda_o = 1'b1;
    end
    task automatic tick;
        repeat (4) @(posedge clk);
        #1;
    endtask : tick
    task automatic start;
        sda_o = 1'b1;
        tick;
        scl = 1'b1;
        tick;
        sda_o = 1'b0;
        tick;
        scl = 1'b0;
        tick;
    endtask : start
    task automatic stop;
        sda_o = 1'b0;
        tick;
        scl = 1'b1;
        tick;
        sda_o = 1'b1;
        tick;
    endtask : stop
    task automatic bitx(input logic b, output logic r);
        sda_o = b;
        tick;
        scl = 1'b1;
        tick;
        r = sda;
        tick;
        scl = 1'b0;
        tick;
    endtask : bitx
    task automatic wbyte(input logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(v[i], r);
        bitx(1'b1, r);
        if (r !== 1'b0) nacks++;
    endtask : wbyte
    task automatic rbyte(input logic last, output logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(1'b1, v[i]);
        bitx(last, r);
    endtask : rbyte
    task automatic wr(input logic [7:0] p, int n, input logic [15:0] v);
        start;
        wbyte({ADDR, 1'b0});
        wbyte(p);
        if (n == 2) wbyte(v[15:8]);
        wbyte(v[7:0]);
        stop;
    endtask : wr
    task automatic rd(input logic [7:0] p, int n, output logic [15:0] v);
        start;
        wbyte({ADDR, 1'b0});
        wbyte(p);
        start;
        wbyte({ADDR, 1'b1});
        v = 16'h0000;
        if (n == 2) rbyte(1'b0, v[15:8]);
        rbyte(1'b1, v[7:0]);
        stop;
    endtask : rd
    task automatic ara;
        logic [7:0] v;
        start;
        wbyte({`TLCS_ARA_ADDR, 1'b1});
        rbyte(1'b1, v);
        stop;
    endtask : ara
endmodule : tlcs_host

// File: testbench/tb.sv
// self-checking bench of the limit compare and status block
`timescale 1ns/1ps
module tb;
    import tlcs_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic scl, host_sda, sda, sda_out, sda_oe_n, int_n, ot2_n, ot_n;
    logic busy = 1'b0, done_l = 1'b0, done_r = 1'b0, open_r = 1'b0;
    tlcs_temp_t res = 12'h000;
    logic [15:0] d;
    int errors = 0, n_tests = 0, cycles = 0;
    always #5 clk = ~clk;
    assign sda = host_sda & (sda_oe_n | sda_out);
    tlcs_top tlcs_top_i (.clk(clk), .nrst(nrst), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .conv_busy(busy),
        .conv_done_local(done_l), .conv_done_remote(done_r),
        .remote_open(open_r), .conv_result(res), .interrupt_out_n(int_n),
        .overtemp2_out_n(ot2_n), .overtemp_out_n(ot_n));
    tlcs_host tlcs_host_i (.clk(clk), .sda(sda), .scl(scl), .sda_o(host_sda));
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : summarize
    always @(posedge clk) begin
        cycles++;
        if (cycles == 90000) begin
            errors++;
            $display("wrong value at %0t: run too long", $time);
            summarize;
        end
    end
    task automatic chk8(input logic [7:0] g, e, input string m);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("wrong value at %0t: %s got %h want %h", $time, m, g, e);
        end
    endtask : chk8
    task automatic chk1(input logic g, e, input string m);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("wrong value at %0t: %s got %b", $time, m, g);
        end
    endtask : chk1
    task automatic rchk(input logic [7:0] p, int n, input logic [15:0] e);
        tlcs_host_i.rd(p, n, d);
        if (n == 2) chk8(d[15:8], e[15:8], "upper byte");
        chk8(d[7:0], e[7:0], "byte");
    endtask : rchk
    task automatic do_reset;
        nrst = 1'b0;
        repeat (20) @(posedge clk);
        #1;
        nrst = 1'b1;
        repeat (5) @(posedge clk);
        #1;
    endtask : do_reset
    task automatic conv(input logic rem, input tlcs_temp_t r, input logic op);
        res = r;
        open_r = op;
        done_l = ~rem;
        done_r = rem;
        @(posedge clk);
        #1;
        done_l = 1'b0;
        done_r = 1'b0;
        repeat (6) @(posedge clk);
        #1;
    endtask : conv
    task automatic t_default;
        conv(1'b0, 12'h550, 1'b0);
        chk1(int_n, 1'b1, "alert at limit");
        conv(1'b0, 12'h551, 1'b0);
        chk1(int_n, 1'b0, "alert above limit");
        chk1(ot_n, 1'b1, "overtemp at limit");
        conv(1'b0, 12'h560, 1'b0);
        chk1(ot_n, 1'b0, "overtemp set");
        conv(1'b0, 12'h4C0, 1'b0);
        chk1(ot_n, 1'b0, "overtemp held");
        conv(1'b0, 12'h4B0, 1'b0);
        chk1(ot_n, 1'b1, "overtemp cleared");
        $display("test default_limits done");
    endtask : t_default
    task automatic t_reset;
        logic [7:0] p [13] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h13, 8'h14,
            8'h16, 8'h17, 8'h19, 8'h20, 8'h21, 8'h02, 8'h40};
        logic [7:0] e [13] = '{8'h55, 8'h00, 8'h55, 8'h00, 8'h00, 8'h00,
            8'h00, 8'h00, 8'h55, 8'h55, 8'h0A, 8'h00, 8'h00};
        for (int i = 0; i < 13; i++)
            rchk(p[i], 1, {8'h00, e[i]});
        $display("test reset_values done");
    endtask : t_reset
    task automatic t_limits;
        logic [7:0] w [4] = '{8'h0B, 8'h0C, 8'h0D, 8'h0E};
        logic [7:0] r [4] = '{8'h05, 8'h06, 8'h07, 8'h08};
        logic [7:0] l [4] = '{8'h16, 8'h17, 8'h13, 8'h14};
        for (int i = 0; i < 4; i++) begin
            tlcs_host_i.wr(w[i], 2, {w[i], 8'hA7});
            rchk(r[i], 2, {w[i], 8'hA0});
            tlcs_host_i.wr(l[i], 1, {8'h00, r[i][3:0], 4'h9});
            rchk(l[i], 1, {8'h00, r[i][3:0], 4'h0});
        end
        tlcs_host_i.wr(8'h20, 1, 16'h0040);
        tlcs_host_i.wr(8'h19, 1, 16'h0050);
        tlcs_host_i.wr(8'h21, 1, 16'h0005);
        tlcs_host_i.wr(8'h02, 1, 16'h00FF);
        rchk(8'h20, 1, 16'h0040);
        rchk(8'h19, 1, 16'h0050);
        rchk(8'h21, 1, 16'h0005);
        rchk(8'h02, 1, 16'h0000);
        tlcs_host_i.wr(8'h09, 1, 16'h00FF);
        rchk(8'h03, 1, 16'h00E4);
        $display("test limit_access done");
    endtask : t_limits
    task automatic t_flags;
        tlcs_host_i.wr(8'h09, 1, 16'h0004);
        tlcs_host_i.wr(8'h0B, 2, 16'h4000);
        tlcs_host_i.wr(8'h0C, 2, 16'h1000);
        tlcs_host_i.wr(8'h0D, 2, 16'h4000);
        tlcs_host_i.wr(8'h0E, 2, 16'h1000);
        conv(1'b0, 12'h401, 1'b0);
        conv(1'b1, 12'h0FF, 1'b0);
        chk1(int_n, 1'b0, "alert low");
        conv(1'b0, 12'h0FF, 1'b0);
        conv(1'b1, 12'h401, 1'b0);
        rchk(8'h02, 1, 16'h0078);
        rchk(8'h02, 1, 16'h0030);
        chk1(int_n, 1'b0, "alert kept");
        tlcs_host_i.ara;
        chk1(int_n, 1'b1, "alert released");
        conv(1'b0, 12'h200, 1'b0);
        conv(1'b1, 12'h200, 1'b0);
        rchk(8'h02, 1, 16'h0030);
        rchk(8'h02, 1, 16'h0000);
        conv(1'b1, 12'h200, 1'b1);
        chk1(int_n, 1'b0, "open alert");
        rchk(8'h02, 1, 16'h0004);
        conv(1'b1, 12'h200, 1'b0);
        rchk(8'h02, 1, 16'h0004);
        rchk(8'h02, 1, 16'h0000);
        tlcs_host_i.ara;
        tlcs_host_i.wr(8'h09, 1, 16'h0080);
        conv(1'b0, 12'h401, 1'b0);
        chk1(int_n, 1'b1, "masked alert");
        rchk(8'h02, 1, 16'h0040);
        $display("test status_flags done");
    endtask : t_flags
    task automatic t_overtemp;
        conv(1'b1, 12'h510, 1'b0);
        chk1(ot_n, 1'b0, "remote overtemp");
        conv(1'b1, 12'h4C0, 1'b0);
        rchk(8'h02, 1, 16'h0052);
        rchk(8'h02, 1, 16'h0052);
        conv(1'b1, 12'h4B0, 1'b0);
        chk1(ot_n, 1'b1, "remote overtemp off");
        $display("test overtemp done");
    endtask : t_overtemp
    task automatic t_mode;
        tlcs_host_i.wr(8'h09, 1, 16'h0020);
        conv(1'b1, 12'h200, 1'b0);
        conv(1'b0, 12'h3A0, 1'b0);
        chk1(ot2_n, 1'b1, "overtemp2 idle");
        conv(1'b0, 12'h401, 1'b0);
        chk1(ot2_n, 1'b0, "overtemp2 low");
        chk1(int_n, 1'b1, "alert unused");
        conv(1'b0, 12'h3C0, 1'b0);
        rchk(8'h02, 1, 16'h0040);
        rchk(8'h02, 1, 16'h0040);
        conv(1'b0, 12'h3B0, 1'b0);
        chk1(ot2_n, 1'b1, "overtemp2 off");
        rchk(8'h02, 1, 16'h0000);
        $display("test pin_mode done");
    endtask : t_mode
    task automatic t_busy;
        busy = 1'b1;
        rchk(8'h02, 1, 16'h0080);
        busy = 1'b0;
        rchk(8'h02, 1, 16'h0000);
        $display("test busy done");
    endtask : t_busy
    initial begin
        do_reset;
        t_default;
        do_reset;
        t_reset;
        t_limits;
        t_flags;
        t_overtemp;
        t_mode;
        t_busy;
        chk8(8'(tlcs_host_i.nacks), 8'h00, "host nacks");
        summarize;
    end
endmodule : tb
